// ===== include/albx_pkg.sv
package albx_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int INSTR_W = 12;
  localparam int PC_W = 9;
  localparam int RADDR_W = 5;
  localparam int BITSEL_W = 3;

  // ----------------------------------------
  // Opcode patterns and masks
  // ----------------------------------------
  localparam logic [11:0] MASK_REGOP = 12'hFC0;
  localparam logic [11:0] PAT_ADD = 12'h1C0;
  localparam logic [11:0] PAT_AND = 12'h140;
  localparam logic [11:0] MASK_IMM = 12'hF00;
  localparam logic [11:0] PAT_AND_IMM = 12'hE00;
  localparam logic [11:0] MASK_BITOP = 12'hF00;
  localparam logic [11:0] PAT_BIT_LOWER = 12'h400;
  localparam logic [11:0] PAT_BIT_RAISE = 12'h500;
  localparam logic [11:0] MASK_JUMP = 12'hE00;
  localparam logic [11:0] PAT_JUMP = 12'hA00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int F_REG_LSB = 0;
  localparam int F_DEST_BIT = 5;
  localparam int F_BIT_LSB = 5;
  localparam int F_IMM_LSB = 0;
  localparam int F_ADDR_LSB = 0;
  localparam int NIB_W = 4;

  // ----------------------------------------
  // Reset values and PC step
  // ----------------------------------------
  localparam logic [8:0] PC_RESET = 9'h000;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [8:0] PC_STEP = 9'h001;

  typedef enum logic [2:0] {
    OP_NONE, OP_ADD, OP_AND, OP_AND_IMM, OP_BIT_LOWER, OP_BIT_RAISE, OP_JUMP
  } albx_op_t;

  typedef enum {ST_RUN, ST_FLUSH} albx_state_t;
endpackage

// ===== hw/albx_decode.sv
`timescale 1ns/1ps
module albx_decode (
  input wire logic [albx_pkg::INSTR_W-1:0] instr_i,
  output albx_pkg::albx_op_t op_o,
  output logic [albx_pkg::RADDR_W-1:0] reg_sel_o,
  output logic dest_reg_o,
  output logic [albx_pkg::BITSEL_W-1:0] bit_sel_o,
  output logic [albx_pkg::DATA_W-1:0] imm_o,
  output logic [albx_pkg::PC_W-1:0] addr_o
);
  import albx_pkg::*;

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  assign reg_sel_o = instr_i[F_REG_LSB +: RADDR_W];
  assign dest_reg_o = instr_i[F_DEST_BIT];
  assign bit_sel_o = instr_i[F_BIT_LSB +: BITSEL_W];
  assign imm_o = instr_i[F_IMM_LSB +: DATA_W];
  assign addr_o = instr_i[F_ADDR_LSB +: PC_W];

  // ----------------------------------------
  // Opcode match
  // ----------------------------------------
  always_comb begin
    op_o = OP_NONE;
    if ((instr_i & MASK_REGOP) == PAT_ADD) begin
      op_o = OP_ADD;
    end else if ((instr_i & MASK_REGOP) == PAT_AND) begin
      op_o = OP_AND;
    end else if ((instr_i & MASK_IMM) == PAT_AND_IMM) begin
      op_o = OP_AND_IMM;
    end else if ((instr_i & MASK_BITOP) == PAT_BIT_LOWER) begin
      op_o = OP_BIT_LOWER;
    end else if ((instr_i & MASK_BITOP) == PAT_BIT_RAISE) begin
      op_o = OP_BIT_RAISE;
    end else if ((instr_i & MASK_JUMP) == PAT_JUMP) begin
      op_o = OP_JUMP;
    end
  end
endmodule

// ===== hw/albx_exec.sv
// Behaviour
// - Register add, flags Z C NC, PC+1
// - Five-bit register number; destination bit selects target
// - Eight-bit two's complement sum
// - Register AND, zero flag only, PC+1
// - Immediate AND into working register, zero flag
// - Bit clear of addressed register, PC+1
// - Bit set of addressed register, PC+1
// - Jump loads nine-bit field into PC
// - Jump takes two cycles, flags unchanged
`timescale 1ns/1ps
module albx_exec (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [albx_pkg::INSTR_W-1:0] instr_i,
  input wire logic [albx_pkg::DATA_W-1:0] rf_rdata_i,
  output logic [albx_pkg::PC_W-1:0] pc_o,
  output logic [albx_pkg::RADDR_W-1:0] rf_addr_o,
  output logic rf_we_o,
  output logic [albx_pkg::DATA_W-1:0] rf_wdata_o,
  output logic [albx_pkg::DATA_W-1:0] working_reg_o,
  output logic zero_o,
  output logic carry_o,
  output logic nib_carry_o,
  output logic flush_o
);
  import albx_pkg::*;

  albx_op_t op;
  logic [RADDR_W-1:0] reg_sel;
  logic dest_reg;
  logic [BITSEL_W-1:0] bit_sel;
  logic [DATA_W-1:0] imm;
  logic [PC_W-1:0] addr;
  albx_state_t state;
  albx_op_t eff_op;
  logic [DATA_W:0] sum;
  logic [NIB_W:0] nib_sum;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] bit_mask;

  albx_decode u_dec (
    .instr_i(instr_i),
    .op_o(op),
    .reg_sel_o(reg_sel),
    .dest_reg_o(dest_reg),
    .bit_sel_o(bit_sel),
    .imm_o(imm),
    .addr_o(addr)
  );

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  // The word fetched behind a jump is killed here so it cannot write anything
  assign eff_op = (state == ST_FLUSH) ? OP_NONE : op;
  assign flush_o = (state == ST_FLUSH);
  assign sum = {1'b0, working_reg_o} + {1'b0, rf_rdata_i};
  assign nib_sum = {1'b0, working_reg_o[NIB_W-1:0]} + {1'b0, rf_rdata_i[NIB_W-1:0]};
  assign bit_mask = DATA_W'(1) << bit_sel;
  assign rf_addr_o = reg_sel;

  always_comb begin
    result = rf_rdata_i;
    case (eff_op)
      OP_ADD: result = sum[DATA_W-1:0];
      OP_AND: result = working_reg_o & rf_rdata_i;
      OP_AND_IMM: result = working_reg_o & imm;
      OP_BIT_LOWER: result = rf_rdata_i & ~bit_mask;
      OP_BIT_RAISE: result = rf_rdata_i | bit_mask;
      default: result = rf_rdata_i;
    endcase
  end

  always_comb begin
    rf_we_o = 1'b0;
    case (eff_op)
      OP_ADD, OP_AND: rf_we_o = dest_reg;
      OP_BIT_LOWER, OP_BIT_RAISE: rf_we_o = 1'b1;
      default: rf_we_o = 1'b0;
    endcase
  end
  assign rf_wdata_o = result;

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_RUN;
    end else begin
      case (state)
        ST_RUN: state <= (op == OP_JUMP) ? ST_FLUSH : ST_RUN;
        ST_FLUSH: state <= ST_RUN;
        default: state <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o <= PC_RESET;
    end else if (eff_op == OP_JUMP) begin
      pc_o <= addr;
    end else begin
      pc_o <= pc_o + PC_STEP;
    end
  end

  // ----------------------------------------
  // Working register and flags
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      working_reg_o <= WREG_RESET;
    end else if (eff_op == OP_AND_IMM
        || ((eff_op == OP_ADD || eff_op == OP_AND) && !dest_reg)) begin
      working_reg_o <= result;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zero_o <= 1'b0;
      carry_o <= 1'b0;
      nib_carry_o <= 1'b0;
    end else begin
      if (eff_op == OP_ADD || eff_op == OP_AND || eff_op == OP_AND_IMM) begin
        zero_o <= (result == '0);
      end
      if (eff_op == OP_ADD) begin
        carry_o <= sum[DATA_W];
        nib_carry_o <= nib_sum[NIB_W];
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_JUMP_PC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_JUMP) |=> (pc_o == $past(addr)))
    else $error("jump target not loaded");
  AST_JUMP_FLUSH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_JUMP) |=> flush_o ##1 !flush_o)
    else $error("jump not two cycles");
  AST_FLUSH_QUIET: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flush_o |-> !rf_we_o ##1 $stable(working_reg_o) && $stable(zero_o))
    else $error("flushed word had effect");
  AST_JUMP_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_JUMP) |=> $stable(zero_o) && $stable(carry_o) && $stable(nib_carry_o))
    else $error("jump changed flags");
  AST_ADD_SUM: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_ADD && !dest_reg) |=>
      working_reg_o == DATA_W'($past(working_reg_o) + $past(rf_rdata_i)))
    else $error("add sum wrong");
  AST_ADD_PC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_ADD) |=> pc_o == PC_W'($past(pc_o) + PC_STEP))
    else $error("pc not advanced");
  AST_AND_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_AND) |=> $stable(carry_o) && $stable(nib_carry_o)
      && zero_o == ($past(result) == '0))
    else $error("and flags wrong");
  AST_AND_IMM_OP_DEST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_AND_IMM) |-> !rf_we_o ##1 working_reg_o == $past(result))
    else $error("and immediate dest wrong");
  AST_BIT_LOWER_OP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_BIT_LOWER) |-> rf_we_o && !rf_wdata_o[bit_sel]
      && ((rf_wdata_o ^ rf_rdata_i) & ~bit_mask) == '0 ##1 $stable(zero_o))
    else $error("bit clear wrong");
  AST_BIT_RAISE_OP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_BIT_RAISE) |-> rf_we_o && rf_wdata_o[bit_sel]
      && ((rf_wdata_o ^ rf_rdata_i) & ~bit_mask) == '0)
    else $error("bit set wrong");
  AST_DEST_REG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_ADD && dest_reg) |-> rf_we_o && rf_addr_o == instr_i[RADDR_W-1:0]
      ##1 $stable(working_reg_o))
    else $error("dest select wrong");

  // ----------------------------------------
  // Checks against the operands, the PC and side effects
  // ----------------------------------------
  // Flags are rebuilt from the sampled operands, so a wrong slice of sum shows up
  AST_ADD_CARRY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_ADD) |=>
      carry_o == ((int'($past(working_reg_o)) + int'($past(rf_rdata_i))) >= (1 << DATA_W)))
    else $error("add carry wrong");
  AST_ADD_NIB: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_ADD) |=> nib_carry_o == ((int'($past(working_reg_o[NIB_W-1:0]))
      + int'($past(rf_rdata_i[NIB_W-1:0]))) >= (1 << NIB_W)))
    else $error("add nibble carry wrong");
  AST_ADD_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_ADD) |=>
      zero_o == (DATA_W'($past(working_reg_o) + $past(rf_rdata_i)) == '0))
    else $error("add zero flag wrong");
  AST_AND_DEST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_AND && dest_reg) |->
      rf_we_o && rf_wdata_o == (working_reg_o & rf_rdata_i))
    else $error("and register result wrong");
  AST_AND_PC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_AND) |=> pc_o == PC_W'($past(pc_o) + PC_STEP))
    else $error("and pc not advanced");
  AST_AND_IMM_OP_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_AND_IMM) |=> $stable(carry_o) && $stable(nib_carry_o)
      && zero_o == (($past(working_reg_o) & $past(instr_i[F_IMM_LSB +: DATA_W])) == '0))
    else $error("and immediate flags wrong");
  AST_BIT_LOWER_OP_PC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_BIT_LOWER) |=> pc_o == PC_W'($past(pc_o) + PC_STEP)
      && $stable(working_reg_o) && $stable(carry_o) && $stable(nib_carry_o))
    else $error("bit clear side effect");
  AST_BIT_RAISE_OP_PC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (eff_op == OP_BIT_RAISE) |=> pc_o == PC_W'($past(pc_o) + PC_STEP)
      && $stable(working_reg_o) && $stable(zero_o) && $stable(carry_o))
    else $error("bit set side effect");
  AST_WREG_DEST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ((eff_op == OP_ADD || eff_op == OP_AND) && !dest_reg) |-> !rf_we_o)
    else $error("file written for working target");
  AST_FLUSH_PC: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flush_o |=> pc_o == PC_W'($past(pc_o) + PC_STEP))
    else $error("flush cycle pc wrong");
  AST_FLUSH_FLAGS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flush_o |=> $stable(carry_o) && $stable(nib_carry_o))
    else $error("flushed word changed carry");
endmodule

// ===== test/albx_rf_model.sv
`timescale 1ns/1ps
module albx_rf_model (
  input wire logic clk_i,
  input wire logic [albx_pkg::RADDR_W-1:0] addr_i,
  input wire logic we_i,
  input wire logic [albx_pkg::DATA_W-1:0] wdata_i,
  output logic [albx_pkg::DATA_W-1:0] rdata_o
);
  import albx_pkg::*;
  logic [DATA_W-1:0] mem [32];
  // ----
  // Storage
  // ----
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'h00;
    end
  end
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
  // Read is combinational: the core expects the word within the cycle
  assign rdata_o = mem[addr_i];
endmodule

// ===== test/arith_logic_bit_branch_exec_test.sv
`timescale 1ns/1ps
module arith_logic_bit_branch_exec_test;
  import albx_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [INSTR_W-1:0] instr_i = 12'h000;
  logic [DATA_W-1:0] rf_rdata;
  logic [DATA_W-1:0] rf_wdata;
  logic [DATA_W-1:0] wreg;
  logic [PC_W-1:0] pc;
  logic [RADDR_W-1:0] rf_addr;
  logic rf_we, zero, carry, nib_carry, flush;
  logic [8:0] exp_pc = 9'h000;
  int errors = 0;
  int n_checks = 0;
  always #25 clk_i = ~clk_i;
  albx_exec dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
    .rf_rdata_i(rf_rdata), .pc_o(pc), .rf_addr_o(rf_addr), .rf_we_o(rf_we),
    .rf_wdata_o(rf_wdata), .working_reg_o(wreg), .zero_o(zero),
    .carry_o(carry), .nib_carry_o(nib_carry), .flush_o(flush));
  albx_rf_model rf_u (.clk_i(clk_i), .addr_i(rf_addr), .we_i(rf_we),
    .wdata_i(rf_wdata), .rdata_o(rf_rdata));
  // ----
  // Tasks
  // ----
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic flags(input logic [2:0] e);
    chk("flags", {6'h00, e}, {6'h00, zero, carry, nib_carry});
  endtask
  // Called at a falling edge; one instruction executes per rising edge
  task automatic run(input logic [11:0] w);
    instr_i = w;
    exp_pc = exp_pc + 9'h001;
    @(negedge clk_i);
    chk("pc", exp_pc, pc);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (12) @(negedge clk_i);
    rf_u.mem[1] = 8'hF8;
    rf_u.mem[2] = 8'h08;
    rst_n_i = 1'b1;
    chk("pc", 9'h000, pc);
    flags(3'b000);
    run(12'h1C1);
    chk("wreg", 9'h0F8, {1'b0, wreg});
    flags(3'b000);
    run(12'h161);
    chk("r1", 9'h0F8, {1'b0, rf_u.mem[1]});
    flags(3'b000);
    run(12'h1E2);
    chk("r2", 9'h000, {1'b0, rf_u.mem[2]});
    chk("wreg", 9'h0F8, {1'b0, wreg});
    flags(3'b111);
    run(12'hE0F);
    chk("wreg", 9'h008, {1'b0, wreg});
    flags(3'b011);
    run(12'h4E1);
    chk("r1", 9'h078, {1'b0, rf_u.mem[1]});
    for (int b = 0; b < 8; b++) begin
      run(12'h51F | (12'(b) << 5));
      chk("r31", (9'h001 << (b + 1)) - 9'h001, {1'b0, rf_u.mem[31]});
    end
    for (int b = 0; b < 8; b++) begin
      run(12'h41F | (12'(b) << 5));
      chk("r31", 9'h0FF & (9'h0FF << (b + 1)), {1'b0, rf_u.mem[31]});
    end
    flags(3'b011);
    instr_i = 12'hBFF;
    exp_pc = 9'h1FF;
    @(negedge clk_i);
    chk("pc", exp_pc, pc);
    chk("flush", 9'h001, {8'h00, flush});
    // Killed word would overwrite r1 and the flags if it ran
    run(12'h1E1);
    chk("r1", 9'h078, {1'b0, rf_u.mem[1]});
    chk("wreg", 9'h008, {1'b0, wreg});
    flags(3'b011);
    chk("flush", 9'h000, {8'h00, flush});
    // AND into the working register with a zero operand sets only the zero flag
    run(12'h142);
    chk("wreg", 9'h000, {1'b0, wreg});
    chk("r2", 9'h000, {1'b0, rf_u.mem[2]});
    flags(3'b111);
    instr_i = 12'h000;
    give_verdict();
  end
  // Tests need well under 100 cycles
  initial begin
    #(50 * 2000);
    errors++;
    give_verdict();
  end
endmodule
